// ==== rtl/sched_pkg.sv ====
// shared types, constants and helpers of the weekly schedule switch
package sched_pkg;
   // ********************
   // weekday encoding
   // ********************
   localparam logic [2:0] DAY_NONE = 3'h0;  // no weekday selected
   localparam logic [2:0] DAY_MON  = 3'h1;
   localparam logic [2:0] DAY_SUN  = 3'h7;
   localparam logic [4:0] HOUR_LAST = 5'h17;  // 23
   localparam logic [5:0] MIN_LAST  = 6'h3b;  // 59
   localparam logic [4:0] HOUR_ZERO = 5'h00;
   localparam logic [5:0] MIN_ZERO  = 6'h00;
   localparam int unsigned NUM_CHAN = 4;
   localparam int unsigned WEEK_MINUTES = 10080;  // replay length
   localparam int unsigned STEP_W = 14;
   // ********************
   // apb register map
   // ********************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CHAN0  = 8'h10;
   localparam logic [7:0] ADDR_CHAN3  = 8'h1c;
   localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;
   // ********************
   // carriers
   // ********************
   typedef struct packed {
      logic [2:0] weekday;  // 1 = monday .. 7 = sunday
      logic [4:0] hour;
      logic [5:0] minute;
   } rtc_time_t;
   typedef struct packed {
      logic [2:0] start_weekday;  // first day of span
      logic [2:0] end_weekday;    // last day of span, none = one day
      logic       on_en;          // on point present
      logic [4:0] on_hour;
      logic [5:0] on_minute;
      logic       off_en;         // off point present
      logic [4:0] off_hour;
      logic [5:0] off_minute;
   } sched_chan_t;
   localparam int unsigned CHAN_W = $bits(sched_chan_t);
   localparam sched_chan_t CHAN_EMPTY = '0;
   typedef enum logic {SCAN_IDLE, SCAN_RUN} scan_state_t;
   // day inside a span that may wrap past sunday
   function automatic logic day_in_span(input logic [2:0] d,
                                        input logic [2:0] s,
                                        input logic [2:0] e);
      if (e == DAY_NONE) return d == s;
      if (s <= e) return (d >= s) && (d <= e);
      return (d >= s) || (d <= e);
   endfunction : day_in_span
   function automatic logic [2:0] prev_day(input logic [2:0] d);
      return (d == DAY_MON) ? DAY_SUN : 3'(d - 3'h1);
   endfunction : prev_day
   // one minute later, wrapping the week
   function automatic rtc_time_t next_minute(input rtc_time_t t);
      rtc_time_t n;
      n = t;
      n.minute = 6'(t.minute + 6'h01);
      if (t.minute == MIN_LAST) begin
         n.minute = MIN_ZERO;
         n.hour   = 5'(t.hour + 5'h01);
         if (t.hour == HOUR_LAST) begin
            n.hour    = HOUR_ZERO;
            n.weekday = (t.weekday == DAY_SUN) ? DAY_MON :
                        3'(t.weekday + 3'h1);
         end
      end
      return n;
   endfunction : next_minute
   // new output from on and off events, off wins a tie
   function automatic logic combine(input logic q, input logic on_ev,
                                    input logic off_ev);
      return off_ev ? 1'b0 : (on_ev ? 1'b1 : q);
   endfunction : combine
endpackage : sched_pkg

// ==== rtl/channel_match.sv ====
// switch point match of one schedule channel against a time
`timescale 1ns/1ps
module channel_match (
   input  sched_pkg::sched_chan_t cfg,
   input  sched_pkg::rtc_time_t   now,
   output logic                   on_hit,
   output logic                   off_hit
);
   import sched_pkg::*;
   logic overnight;  // off earlier than on moves the off to next day
   logic off_day;
   // ********************
   // event decode
   // ********************
   always_comb begin
      overnight = cfg.on_en && ({cfg.off_hour, cfg.off_minute} <
                                {cfg.on_hour, cfg.on_minute});
      // off falls on the day after each spanned day when overnight
      off_day = overnight ?
         day_in_span(prev_day(now.weekday), cfg.start_weekday,
                     cfg.end_weekday) :
         day_in_span(now.weekday, cfg.start_weekday,
                     cfg.end_weekday);
      // an absent point yields no event at all
      on_hit = cfg.on_en && (cfg.start_weekday != DAY_NONE) &&
         day_in_span(now.weekday, cfg.start_weekday, cfg.end_weekday) &&
         now.hour == cfg.on_hour && now.minute == cfg.on_minute;
      off_hit = cfg.off_en && (cfg.start_weekday != DAY_NONE) &&
         off_day && now.hour == cfg.off_hour &&
         now.minute == cfg.off_minute;
   end
endmodule : channel_match

// ==== rtl/time_walker.sv ====
// virtual clock that replays a week minute by minute
`timescale 1ns/1ps
module time_walker (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               load,
   input  sched_pkg::rtc_time_t    load_time,
   input  wire logic               step,
   output sched_pkg::rtc_time_t    vtime
);
   import sched_pkg::*;
   // ********************
   // minute counter
   // ********************
   // load starts one minute after now so a full week ends on now
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vtime <= '0;
      end else if (load) begin
         vtime <= next_minute(load_time);
      end else if (step) begin
         vtime <= next_minute(vtime);
      end
   end
endmodule : time_walker

// ==== rtl/weekly_schedule_block.sv ====
// weekly schedule switch: four channels, apb registers, week replay
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module weekly_schedule_block #(
   parameter int unsigned REPLAY_STEPS = sched_pkg::WEEK_MINUTES
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             enable,
   input  wire logic             power_good,
   input  wire logic             minute_tick,
   input  sched_pkg::rtc_time_t  rtc_time,
   output logic                  switch_output
);
   import sched_pkg::*;

   // ********************
   // declarations
   // ********************
   sched_chan_t              chan_cfg [NUM_CHAN];  // channel settings
   logic                     release_check;  // honour enable input
   logic [NUM_CHAN-1:0]      live_on;   // on hits at real time
   logic [NUM_CHAN-1:0]      live_off;  // off hits at real time
   logic [NUM_CHAN-1:0]      virt_on;   // on hits at replay time
   logic [NUM_CHAN-1:0]      virt_off;  // off hits at replay time
   rtc_time_t                vtime;     // replay time
   scan_state_t              scan_state;
   logic [STEP_W-1:0]        step_cnt;  // replay minutes done
   logic                     replay_q;  // output as the replay sees it
   logic                     running;   // power up and released
   logic                     run_q;     // running one cycle ago
   logic                     tick;      // minute tick while running
   logic                     cfg_wr;    // accepted channel write
   logic                     start;     // begin or restart replay
   logic                     last_step; // final replay minute
   logic                     wr_acc;    // apb write access phase
   logic                     rd_acc;    // apb read access phase
   logic                     chan_sel;  // address hits a channel
   logic [1:0]               chan_idx;  // channel addressed
   sched_chan_t              wr_chan;   // channel word being written
   logic                     wr_ok;     // channel times in range
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(REPLAY_STEPS - 1);

   // ********************
   // helpers
   // ********************
   // hour and minute form only, midnight to last minute
   function automatic logic time_ok(input sched_chan_t c);
      return c.on_hour <= HOUR_LAST && c.on_minute <= MIN_LAST &&
             c.off_hour <= HOUR_LAST && c.off_minute <= MIN_LAST &&
             c.start_weekday <= DAY_SUN &&
             c.end_weekday <= DAY_SUN;
   endfunction : time_ok

   // fill in missing parts of an entry the way the editor would
   function automatic sched_chan_t normalize(input sched_chan_t o,
                                             input sched_chan_t n);
      sched_chan_t r;
      r = n;
      if (n.start_weekday == DAY_NONE && n.end_weekday == DAY_NONE) begin
         if (o.start_weekday != DAY_NONE || !(n.on_en || n.off_en)) begin
            r = CHAN_EMPTY;
         end else begin
            r.start_weekday = DAY_SUN;  // time alone defaults
         end
      end else if (n.start_weekday == DAY_NONE) begin
         r.start_weekday = DAY_SUN;
         r.on_en = 1'b1;
         r.on_hour = HOUR_ZERO;
         r.on_minute = MIN_ZERO;
      end else if (!n.on_en && !n.off_en) begin
         r.on_en = 1'b1;  // no on or off set: on at 00:00, output stays on
         r.on_hour = HOUR_ZERO;
         r.on_minute = MIN_ZERO;
      end
      return r;
   endfunction : normalize

   // ********************
   // channel evaluation
   // ********************
   // one live and one replay matcher per channel
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      channel_match u_live (
         .cfg     (chan_cfg[i]),
         .now     (rtc_time),
         .on_hit  (live_on[i]),
         .off_hit (live_off[i])
      );
      channel_match u_virt (
         .cfg     (chan_cfg[i]),
         .now     (vtime),
         .on_hit  (virt_on[i]),
         .off_hit (virt_off[i])
      );
   end

   // ********************
   // run control
   // ********************
   // enable only counts when the release option is set
   assign running = power_good &&
                    (!release_check || enable);
   assign tick = running && minute_tick;
   assign last_step = (scan_state == SCAN_RUN) && (step_cnt == STEP_LAST);
   // a tick mid replay restarts it so no minute is lost
   assign start = running && (!run_q || cfg_wr ||
                  (scan_state == SCAN_RUN && tick));

   // previous run level, for the rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
      end else begin
         run_q <= running;
      end
   end

   // ********************
   // week replay
   // ********************
   time_walker u_walk (
      .pclk      (pclk),
      .presetn   (presetn),
      .load      (start),
      .load_time (rtc_time),
      .step      (scan_state == SCAN_RUN),
      .vtime     (vtime)
   );

   // replay sequencer; costs a week of cycles, about half a millisecond
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_state <= SCAN_IDLE;
         step_cnt <= '0;
         replay_q <= 1'b0;
      end else if (!running) begin
         scan_state <= SCAN_IDLE;  // nothing runs without power
         step_cnt <= '0;
      end else if (start) begin
         scan_state <= SCAN_RUN;
         step_cnt <= '0;
         replay_q <= 1'b0;
      end else begin
         unique case (scan_state)
            SCAN_IDLE: begin
               step_cnt <= '0;
            end
            SCAN_RUN: begin
               replay_q <= combine(replay_q, |virt_on, |virt_off);
               step_cnt <= STEP_W'(step_cnt + 1'b1);
               if (last_step) begin
                  scan_state <= SCAN_IDLE;
               end
            end
         endcase
      end
   end

   // ********************
   // switch output
   // ********************
   // held open without power or release; rebuilt by the replay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_output <= 1'b0;
      end else if (!running) begin
         switch_output <= 1'b0;
      end else if (last_step && !start) begin
         switch_output <= combine(replay_q, |virt_on,
                                  |virt_off);
      end else if (scan_state == SCAN_IDLE && tick) begin
         switch_output <= combine(switch_output, |live_on,
                                  |live_off);
      end
   end

   // ********************
   // apb slave
   // ********************
   assign pready   = 1'b1;  // zero wait states
   assign wr_acc   = psel && penable && pwrite;
   assign rd_acc   = psel && penable && !pwrite;
   assign chan_sel = paddr >= ADDR_CHAN0 && paddr <= ADDR_CHAN3 &&
                     paddr[1:0] == 2'h0;
   assign chan_idx = 2'(paddr[3:2]);
   assign wr_chan  = sched_chan_t'(pwdata[CHAN_W-1:0]);
   assign wr_ok    = time_ok(wr_chan);
   assign cfg_wr   = wr_acc && chan_sel && wr_ok;

   // unmapped addresses and out of range times answer with an error
   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         if (!(chan_sel || paddr == ADDR_CTRL || paddr == ADDR_STATUS)) begin
            pslverr = 1'b1;
         end else if (wr_acc && chan_sel && !wr_ok) begin
            pslverr = 1'b1;
         end
      end
   end

   // release option
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         release_check <= 1'b0;
      end else if (wr_acc && paddr == ADDR_CTRL) begin
         release_check <= pwdata[0];
      end
   end

   // channel settings, accepted whenever written with times in range
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            chan_cfg[i] <= CHAN_EMPTY;
         end
      end else if (cfg_wr) begin
         chan_cfg[chan_idx] <= normalize(chan_cfg[chan_idx],
                                         wr_chan);
      end
   end

   // read data registered at the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= DATA_ZERO;
      end else if (psel && !penable && !pwrite) begin
         prdata <= DATA_ZERO;
         if (paddr == ADDR_CTRL) begin
            prdata <= {31'h0, release_check};
         end else if (paddr == ADDR_STATUS) begin
            prdata <= {28'h0, running, power_good,
                       scan_state == SCAN_RUN, switch_output};
         end else if (chan_sel) begin
            prdata <= 32'(chan_cfg[chan_idx]);
         end
      end
   end

   // ********************
   // checks
   // ********************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_power_loss_open: assert property (
      !power_good |=> !switch_output)
      else $error("output not open after power loss");
   // one cycle only: a tick on the edge that re-releases may set it
   chk_release_gate: assert property (
      release_check && !enable |=> !switch_output)
      else $error("output on while not released");
   // raw tick, not the gated one, so a wrongly gated enable shows up
   chk_enable_ignored: assert property (
      !release_check && !enable && power_good && minute_tick &&
      scan_state == SCAN_IDLE && |live_on && !(|live_off) && !start
      |=> switch_output)
      else $error("enable input not ignored");
   chk_off_wins_tie: assert property (
      tick && scan_state == SCAN_IDLE && |live_off && !start
      |=> !switch_output)
      else $error("off event did not clear output");
   chk_on_sets_out: assert property (
      tick && scan_state == SCAN_IDLE && |live_on && !(|live_off) &&
      !start |=> switch_output)
      else $error("on event did not set output");
   chk_hold_no_tick: assert property (
      running && !tick && scan_state == SCAN_IDLE && !start
      |=> $stable(switch_output))
      else $error("output moved without a minute tick");
   chk_bad_time_err: assert property (
      wr_acc && chan_sel && !wr_ok |-> pslverr ##1
      $stable(chan_cfg[chan_idx]))
      else $error("out of range time not refused");
   chk_restore_scan: assert property (
      running && !run_q |=> scan_state == SCAN_RUN)
      else $error("no recompute after power return");
   chk_empty_chan: assert property (
      chan_cfg[0].start_weekday == DAY_NONE |->
      !chan_cfg[0].on_en && !chan_cfg[0].off_en)
      else $error("empty channel holds a switch point");

   cov_replay_done: cover property (last_step);
   cov_output_rise: cover property (!switch_output ##1 switch_output);
   cov_tie_event: cover property (tick && |live_on && |live_off);
   cov_overnight: cover property (
      chan_cfg[0].on_en && chan_cfg[0].off_en &&
      {chan_cfg[0].off_hour, chan_cfg[0].off_minute} <
      {chan_cfg[0].on_hour, chan_cfg[0].on_minute});
endmodule : weekly_schedule_block

// ==== test/rtc_model.sv ====
// behavioural calendar clock that feeds the schedule switch
`timescale 1ns/1ps
module rtc_model (
   input  wire logic            pclk,
   output sched_pkg::rtc_time_t rtc_time,
   output logic                 minute_tick
);
   import sched_pkg::*;
   // ********************
   // clock state
   // ********************
   // a real clock never shows a blank time, so start on monday 00:00
   initial begin
      rtc_time    = '{weekday: DAY_MON, hour: HOUR_ZERO, minute: MIN_ZERO};
      minute_tick = 1'b0;
   end
   // new minute: time and a one-cycle tick change together
   task automatic tick(input rtc_time_t t);
      rtc_time    <= t;  // weekday 1..7 and legal hh:mm only
      minute_tick <= 1'b1;
      @(posedge pclk);
      minute_tick <= 1'b0;  // time is held between ticks
   endtask : tick
endmodule : rtc_model

// ==== test/tb.sv ====
// self-checking bench of the weekly schedule switch
`timescale 1ns/1ps
module tb;
   import sched_pkg::*;
   // ********************
   // signals
   // ********************
   localparam int unsigned STEPS = 16;  // short replay keeps runs brief
   logic        pclk       = 1'b0;
   logic        presetn    = 1'b0;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [7:0]  paddr      = 8'h00;
   logic [31:0] pwdata     = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        enable     = 1'b0;
   logic        power_good = 1'b1;
   rtc_time_t   rtc_time;
   logic        minute_tick;
   logic        switch_output;
   int          miscompares = 0;
   int          check_count = 0;
   integer      seed = 963;
   sched_chan_t chans [4];      // bench copy of the channel settings
   logic        qm;             // expected output, unknown after a replay
   logic        run_ok = 1'b1;  // block expected to be running
   logic [31:0] rd;             // last read data
   logic        err;            // last error response
   always #25 pclk = ~pclk;
   weekly_schedule_block #(.REPLAY_STEPS(STEPS)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enable(enable),
      .power_good(power_good), .minute_tick(minute_tick),
      .rtc_time(rtc_time), .switch_output(switch_output));
   rtc_model u_rtc (.pclk(pclk), .rtc_time(rtc_time),
                    .minute_tick(minute_tick));
   // ********************
   // checks and verdict
   // ********************
   task automatic check_word(input string w, input logic [31:0] e,
                             input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask : check_word
   // an unknown expectation (right after a replay) is not compared
   task automatic check_bit(input string w, input logic e, input logic g);
      if (e === 1'bx) return;
      check_word(w, {31'h0, e}, {31'h0, g});
   endtask : check_bit
   task automatic give_verdict();
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   // ********************
   // bus and clock drivers
   // ********************
   // entered just after a rising edge; request held until pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // wait out the replay that a write or a restart launches
   task automatic settle();
      int n;
      // the replay begins one edge after run rises; poll after it
      @(posedge pclk);
      n = 0;
      do begin
         apb(1'b0, ADDR_STATUS, DATA_ZERO);
         n++;
      end while (rd[1] !== 1'b0 && n < 40);
      repeat (2) @(posedge pclk);
      qm = 1'bx;
   endtask : settle
   function automatic sched_chan_t mk(input logic [2:0] s, e,
      input logic oe, input logic [4:0] oh, input logic [5:0] om,
      input logic fe, input logic [4:0] fh, input logic [5:0] fm);
      return '{s, e, oe, oh, om, fe, fh, fm};
   endfunction : mk
   task automatic put_chan(input int i, input sched_chan_t c);
      apb(1'b1, ADDR_CHAN0 + 8'(4 * i), {2'b00, c});
      chans[i] = c;
      settle();
   endtask : put_chan
   // write raw, read back the stored form
   task automatic norm(input int i, input sched_chan_t w, input sched_chan_t e);
      apb(1'b1, ADDR_CHAN0 + 8'(4 * i), {2'b00, w});
      apb(1'b0, ADDR_CHAN0 + 8'(4 * i), DATA_ZERO);
      check_word("chan readback", {2'b00, e}, rd);
      chans[i] = e;
      settle();
   endtask : norm
   // ********************
   // expectation
   // ********************
   function automatic logic in_span(input logic [2:0] d, s, e);
      if (e == 3'h0) return d == s;
      if (s <= e) return d >= s && d <= e;
      return d >= s || d <= e;
   endfunction : in_span
   // off points earlier than on points land on the day after
   function automatic logic exp_q(input logic q, input rtc_time_t t);
      logic        on_ev;
      logic        off_ev;
      logic [2:0]  pd;
      sched_chan_t c;
      on_ev = 1'b0;
      off_ev = 1'b0;
      pd = (t.weekday == 3'h1) ? 3'h7 : t.weekday - 3'h1;
      foreach (chans[i]) begin
         c = chans[i];
         if (c.on_en && in_span(t.weekday, c.start_weekday, c.end_weekday)
             && {t.hour, t.minute} == {c.on_hour, c.on_minute}) on_ev = 1'b1;
         if (c.off_en && {t.hour, t.minute} == {c.off_hour, c.off_minute}
             && in_span((c.on_en && {c.off_hour, c.off_minute} <
                 {c.on_hour, c.on_minute}) ? pd : t.weekday,
                 c.start_weekday, c.end_weekday)) off_ev = 1'b1;
      end
      return off_ev ? 1'b0 : (on_ev ? 1'b1 : q);
   endfunction : exp_q
   task automatic tick(input logic [2:0] d, input logic [4:0] h,
                       input logic [5:0] m);
      rtc_time_t t;
      t = '{weekday: d, hour: h, minute: m};
      u_rtc.tick(t);
      qm = run_ok ? exp_q(qm, t) : 1'b0;
      repeat (3) @(posedge pclk);
      check_bit("switch_output", qm, switch_output);
      repeat (20) @(posedge pclk);
   endtask : tick
   // ********************
   // scenarios
   // ********************
   initial begin
      logic [2:0] s;
      logic [4:0] oh;
      logic [4:0] fh;
      logic [5:0] om;
      logic [5:0] fm;
      foreach (chans[i]) chans[i] = CHAN_EMPTY;
      qm = 1'bx;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ADDR_CHAN0 + 8'(4 * i), DATA_ZERO);
         check_word("chan reset", DATA_ZERO, rd);
      end
      apb(1'b1, 8'h40, 32'hffff_ffff);
      check_bit("unmapped err", 1'b1, err);
      put_chan(0, mk(3'h1, 3'h0, 1'b1, 5'h16, 6'h00, 1'b1, 5'h06, 6'h00));
      tick(3'h1, 5'h16, 6'h00);
      tick(3'h1, 5'h06, 6'h00);
      tick(3'h2, 5'h06, 6'h00);
      put_chan(0, mk(3'h6, 3'h1, 1'b1, 5'h0a, 6'h00, 1'b1, 5'h12, 6'h00));
      tick(3'h1, 5'h0a, 6'h00);
      tick(3'h1, 5'h12, 6'h00);
      tick(3'h4, 5'h0a, 6'h00);
      put_chan(1, mk(3'h2, 3'h0, 1'b1, 5'h12, 6'h00, 1'b0, 5'h00, 6'h00));
      put_chan(2, mk(3'h6, 3'h0, 1'b0, 5'h00, 6'h00, 1'b1, 5'h06, 6'h00));
      put_chan(3, mk(3'h7, 3'h0, 1'b0, 5'h00, 6'h00, 1'b1, 5'h0a, 6'h00));
      tick(3'h2, 5'h12, 6'h00);
      tick(3'h3, 5'h12, 6'h00);
      tick(3'h6, 5'h06, 6'h00);
      tick(3'h6, 5'h0a, 6'h00);
      tick(3'h7, 5'h0a, 6'h00);
      norm(1, mk(3'h1, 3'h0, 1'b0, 5'h00, 6'h00, 1'b0, 5'h00, 6'h00),
           mk(3'h1, 3'h0, 1'b1, 5'h00, 6'h00, 1'b0, 5'h00, 6'h00));
      tick(3'h1, 5'h00, 6'h00);
      norm(2, mk(3'h0, 3'h5, 1'b0, 5'h00, 6'h00, 1'b1, 5'h08, 6'h00),
           mk(3'h7, 3'h5, 1'b1, 5'h00, 6'h00, 1'b1, 5'h08, 6'h00));
      norm(2, CHAN_EMPTY, CHAN_EMPTY);
      norm(2, mk(3'h0, 3'h0, 1'b1, 5'h09, 6'h00, 1'b0, 5'h00, 6'h00),
           mk(3'h7, 3'h0, 1'b1, 5'h09, 6'h00, 1'b0, 5'h00, 6'h00));
      apb(1'b1, ADDR_CHAN0 + 8'h08, {2'b00, mk(3'h1, 3'h0, 1'b1, 5'h18,
          6'h00, 1'b0, 5'h00, 6'h00)});
      check_bit("bad hour err", 1'b1, err);
      apb(1'b1, ADDR_CHAN0 + 8'h08, {2'b00, mk(3'h1, 3'h0, 1'b1, 5'h00,
          6'h3c, 1'b0, 5'h00, 6'h00)});
      check_bit("bad minute err", 1'b1, err);
      apb(1'b0, ADDR_CHAN0 + 8'h08, DATA_ZERO);
      check_word("kept chan", {2'b00, chans[2]}, rd);
      settle();
      for (int k = 0; k < 6; k++) begin
         s = 3'($unsigned($random(seed)) % 7 + 1);
         oh = 5'($unsigned($random(seed)) % 24);
         om = 6'($unsigned($random(seed)) % 60);
         fh = 5'($unsigned($random(seed)) % 24);
         fm = 6'($unsigned($random(seed)) % 60);
         put_chan(k % 4, mk(s, 3'h0, 1'b1, oh, om, 1'b1, fh, fm));
         enable <= 1'($random(seed));
         tick(s, oh, om);
         tick(({fh, fm} < {oh, om}) ? ((s == 3'h7) ? 3'h1 : s + 3'h1) : s,
              fh, fm);
      end
      put_chan(0, mk(3'h1, 3'h0, 1'b1, 5'h0a, 6'h05, 1'b1, 5'h0c, 6'h00));
      enable <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      run_ok = 1'b0;
      repeat (2) @(posedge pclk);
      check_bit("disabled out", 1'b0, switch_output);
      tick(3'h1, 5'h0a, 6'h05);
      enable <= 1'b1;
      run_ok = 1'b1;
      settle();
      tick(3'h1, 5'h0a, 6'h05);
      enable <= 1'b0;
      repeat (3) @(posedge pclk);
      check_bit("enable drop", 1'b0, switch_output);
      apb(1'b1, ADDR_CTRL, DATA_ZERO);
      run_ok = 1'b1;
      settle();
      tick(3'h1, 5'h0a, 6'h05);
      power_good <= 1'b0;
      run_ok = 1'b0;
      repeat (3) @(posedge pclk);
      check_bit("power lost out", 1'b0, switch_output);
      apb(1'b0, ADDR_STATUS, DATA_ZERO);
      check_word("status power lost", DATA_ZERO, rd);
      tick(3'h1, 5'h0a, 6'h00);
      power_good <= 1'b1;
      run_ok = 1'b1;
      settle();
      check_bit("power return", 1'b1, switch_output);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check_bit("reset out", 1'b0, switch_output);
      presetn <= 1'b1;
      foreach (chans[i]) chans[i] = CHAN_EMPTY;
      settle();
      apb(1'b0, ADDR_CHAN0, DATA_ZERO);
      check_word("chan after reset", DATA_ZERO, rd);
      give_verdict();
   end
   // a hang ends the run through the same verdict
   initial begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      give_verdict();
   end
endmodule : tb
